// ==== shared/bitaddr_defines.svh ====
// Offsets, field positions, reset values and widths of the bit-address block
`ifndef BITADDR_DEFINES_SVH
`define BITADDR_DEFINES_SVH

// Datapath widths
`define PTR_W         23
`define LOW_W         16
`define OFS_W         16
`define ACC_W         40
`define BITPOS_W      6

// Register byte offsets on the bus
`define OFS_CTRL      12'h000
`define OFS_POINTER   12'h004
`define OFS_FIRST     12'h008
`define OFS_SECOND    12'h00c
`define OFS_PTRZERO   12'h010
`define OFS_BSTART    12'h014
`define OFS_ACC_LO    12'h018
`define OFS_ACC_HI    12'h01c
`define OFS_CMD       12'h020
`define OFS_STATUS    12'h024
`define OFS_ADDR      12'h028

// Control register fields
`define CTRL_COMPAT   0
`define CTRL_CIRC     1

// Command register fields
`define CMD_MODE_LSB  0
`define CMD_MODE_MSB  2
`define CMD_OP_LSB    4
`define CMD_OP_MSB    5

// Status register fields
`define ST_FLAG_ONE   0
`define ST_FLAG_TWO   1

// Reset values
`define RST_WORD      32'h0000_0000

`endif

// ==== shared/bitaddr_pkg.sv ====
// Types shared by the bit-address block
package bitaddr_pkg;

    // Operand forms
    typedef enum logic [2:0] {
        MODE_REV_DEC  = 3'h0,
        MODE_INC_SEC  = 3'h1,
        MODE_DEC_SEC  = 3'h2,
        MODE_IDX_SEC  = 3'h3
    } mode_e;

    // Bit operations on the accumulator
    typedef enum logic [1:0] {
        OP_SET   = 2'h0,
        OP_CLEAR = 2'h1,
        OP_PAIR  = 2'h2,
        OP_NONE  = 2'h3
    } op_e;

    // Execute sequencer states, Gray coded
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ADDR   = 2'b01,
        ST_UPDATE = 2'b11
    } state_e;

endpackage

// ==== design/rev_carry_adder.sv ====
// Adder with carries running from the top bit toward bit zero
`timescale 1ns/1ps
`include "bitaddr_defines.svh"

module rev_carry_adder (
    // Operands
    input  wire logic [`PTR_W-1:0] base,
    input  wire logic [`PTR_W-1:0] operand,
    input  wire logic              subtract,
    // Result
    output logic      [`PTR_W-1:0] sum
);

    // Mirror a word end for end
    function automatic logic [`PTR_W-1:0] mirror(input logic [`PTR_W-1:0] v);
        logic [`PTR_W-1:0] r;
        r = '0;
        for (int i = 0; i < `PTR_W; i++) begin
            r[i] = v[`PTR_W-1-i];
        end
        return r;
    endfunction

    logic [`PTR_W-1:0] rb;
    logic [`PTR_W-1:0] ro;

    // Mirror, add or subtract, mirror back
    always_comb begin
        rb = mirror(base);
        ro = mirror(operand);
        if (subtract) begin
            sum = mirror(rb - ro);
        end else begin
            sum = mirror(rb + ro);
        end
    end

endmodule // rev_carry_adder

// ==== design/bit_op_unit.sv ====
// Set, clear and pair-test of one accumulator bit
`timescale 1ns/1ps
`include "bitaddr_defines.svh"

module bit_op_unit (
    // Operation
    input  wire logic [1:0]          op,
    input  wire logic [`PTR_W-1:0]   bit_addr,
    input  wire logic [`ACC_W-1:0]   acc_in,
    // Results
    output logic      [`ACC_W-1:0]   acc_out,
    output logic                     flag_one,
    output logic                     flag_two,
    output logic                     is_pair
);

    logic [`BITPOS_W-1:0] pos;
    logic [`BITPOS_W-1:0] pos_up;

    // Bit position taken from the low bits of the address
    always_comb begin
        pos      = bit_addr[`BITPOS_W-1:0];
        pos_up   = pos + 6'h01;
        acc_out  = acc_in;
        flag_one = 1'b0;
        flag_two = 1'b0;
        is_pair  = 1'b0;
        case (bitaddr_pkg::op_e'(op))
            bitaddr_pkg::OP_SET: begin
                if (pos < 6'h28) acc_out[pos] = 1'b1;
            end
            bitaddr_pkg::OP_CLEAR: begin
                if (pos < 6'h28) acc_out[pos] = 1'b0;
            end
            bitaddr_pkg::OP_PAIR: begin
                is_pair = 1'b1;
                if (pos < 6'h28) flag_one = acc_in[pos];
                if (pos_up < 6'h28) flag_two = acc_in[pos_up];
            end
            default: begin
                acc_out = acc_in;
            end
        endcase
    end

endmodule // bit_op_unit

// ==== design/bit_access_address_gen.sv ====
// Bit-address generation and pointer update with an AHB-Lite register file
// Overview of operation
// - Bit-reverse decrement, mode clear: address is pointer, subtract first offset reversed.
// - Mode bit set: subtract pointer zero instead, still with reversed carries.
// - Bit-reverse forms never treat the pointer as circular.
// - Circular config with bit-reverse: add sign-extended buffer start to the address only, pointer update unaffected.
// - Pair test copies bit at address to flag one, next bit to flag two.
// - Increment-second form: address is pointer plus optional start, then pointer plus second offset.
// - Decrement-second form: address is pointer plus optional start, then pointer minus second offset.
// - Indexed form: pointer plus optional start plus second offset, pointer unchanged.
// - Bit clear clears the accumulator bit at the generated address.
// - Bit set sets the accumulator bit at the generated address.
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "bitaddr_defines.svh"

module bit_access_address_gen (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Status outputs
    output logic             test_flag_one,
    output logic             test_flag_two,
    output logic             busy
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0]         ctrl;
    logic [`PTR_W-1:0]   extended_aux_pointer;
    logic [`OFS_W-1:0]   first_offset_reg;
    logic [`OFS_W-1:0]   second_offset_reg;
    logic [`PTR_W-1:0]   extended_aux_pointer_zero;
    logic [`OFS_W-1:0]   buffer_start_value;
    logic [`ACC_W-1:0]   acc;
    logic [2:0]          cmd_mode;
    logic [1:0]          cmd_op;
    logic [`PTR_W-1:0]   bit_addr;
    bitaddr_pkg::state_e state;

    // Bus address phase capture
    logic                wr_pend;
    logic                rd_pend;
    logic [11:0]         addr_q;
    logic                start_cmd;

    logic compat_mode_bit;
    logic circ_cfg;
    assign compat_mode_bit = ctrl[`CTRL_COMPAT];
    assign circ_cfg        = ctrl[`CTRL_CIRC];

    // Sign extension of a 16-bit value to pointer width
    function automatic logic [`PTR_W-1:0] sext(input logic [15:0] v);
        return {{(`PTR_W-16){v[15]}}, v};
    endfunction

    // Zero extension of a 16-bit value to pointer width
    function automatic logic [`PTR_W-1:0] zext(input logic [15:0] v);
        return {{(`PTR_W-16){1'b0}}, v};
    endfunction

    // ****************************************************************
    // Address generation
    // ****************************************************************
    logic [`PTR_W-1:0] gen_addr;
    logic [`PTR_W-1:0] rev_operand;
    logic [`PTR_W-1:0] rev_sum;
    logic [`PTR_W-1:0] next_pointer;
    logic [`PTR_W-1:0] start_term;

    // Buffer start term used only when circular addressing is selected
    assign start_term = circ_cfg ? sext(buffer_start_value) : '0;

    // Bit address per operand form
    always_comb begin
        case (bitaddr_pkg::mode_e'(cmd_mode))
            bitaddr_pkg::MODE_REV_DEC:
                gen_addr = extended_aux_pointer + start_term;
            bitaddr_pkg::MODE_INC_SEC:
                gen_addr = extended_aux_pointer + start_term;
            bitaddr_pkg::MODE_DEC_SEC:
                gen_addr = extended_aux_pointer + start_term;
            bitaddr_pkg::MODE_IDX_SEC:
                gen_addr = extended_aux_pointer + start_term
                         + sext(second_offset_reg);
            default:
                gen_addr = extended_aux_pointer;
        endcase
    end

    // Subtrahend of the reversed-carry update
    assign rev_operand = compat_mode_bit ? extended_aux_pointer_zero
                                         : zext(first_offset_reg);

    rev_carry_adder u_rev (
        .base    (extended_aux_pointer),
        .operand (rev_operand),
        .subtract(1'b1),
        .sum     (rev_sum)
    );

    // Post-access pointer value; bit-reverse never wraps circularly
    always_comb begin
        case (bitaddr_pkg::mode_e'(cmd_mode))
            bitaddr_pkg::MODE_REV_DEC:
                next_pointer = rev_sum;
            bitaddr_pkg::MODE_INC_SEC:
                next_pointer = extended_aux_pointer
                             + sext(second_offset_reg);
            bitaddr_pkg::MODE_DEC_SEC:
                next_pointer = extended_aux_pointer
                             - sext(second_offset_reg);
            default:
                next_pointer = extended_aux_pointer;
        endcase
    end

    // ****************************************************************
    // Bit operation
    // ****************************************************************
    logic [`ACC_W-1:0] acc_new;
    logic              flag_one_new;
    logic              flag_two_new;
    logic              pair_op;

    bit_op_unit u_bitop (
        .op      (cmd_op),
        .bit_addr(bit_addr),
        .acc_in  (acc),
        .acc_out (acc_new),
        .flag_one(flag_one_new),
        .flag_two(flag_two_new),
        .is_pair (pair_op)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Idle, latch address, then apply bit op and pointer update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= bitaddr_pkg::ST_IDLE;
        end else begin
            case (state)
                bitaddr_pkg::ST_IDLE:
                    if (start_cmd) state <= bitaddr_pkg::ST_ADDR;
                bitaddr_pkg::ST_ADDR:
                    state <= bitaddr_pkg::ST_UPDATE;
                bitaddr_pkg::ST_UPDATE:
                    state <= bitaddr_pkg::ST_IDLE;
                default:
                    state <= bitaddr_pkg::ST_IDLE;
            endcase
        end
    end

    assign busy = (state != bitaddr_pkg::ST_IDLE);

    // Generated address held for the bit operation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_addr <= '0;
        end else if (state == bitaddr_pkg::ST_ADDR) begin
            bit_addr <= gen_addr;
        end
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    // Capture a valid address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q  <= 12'h000;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            rd_pend <= hsel && htrans[1] && !hwrite;
            addr_q  <= haddr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign start_cmd = wr_pend && (addr_q == `OFS_CMD)
                    && (state == bitaddr_pkg::ST_IDLE);

    // Software writes; execution updates pointer and accumulator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl                      <= `RST_WORD;
            extended_aux_pointer      <= '0;
            first_offset_reg          <= '0;
            second_offset_reg         <= '0;
            extended_aux_pointer_zero <= '0;
            buffer_start_value        <= '0;
            acc                       <= '0;
            cmd_mode                  <= 3'h0;
            cmd_op                    <= 2'h3;
        end else if (state == bitaddr_pkg::ST_UPDATE) begin
            extended_aux_pointer <= next_pointer;
            acc                  <= acc_new;
        end else if (wr_pend) begin
            case (addr_q)
                `OFS_CTRL:    ctrl <= hwdata & 32'h0000_0003;
                `OFS_POINTER: extended_aux_pointer <= hwdata[`PTR_W-1:0];
                `OFS_FIRST:   first_offset_reg <= hwdata[15:0];
                `OFS_SECOND:  second_offset_reg <= hwdata[15:0];
                `OFS_PTRZERO: extended_aux_pointer_zero <= hwdata[`PTR_W-1:0];
                `OFS_BSTART:  buffer_start_value <= hwdata[15:0];
                `OFS_ACC_LO:  acc[31:0] <= hwdata;
                `OFS_ACC_HI:  acc[`ACC_W-1:32] <= hwdata[7:0];
                `OFS_CMD: begin
                    if (state == bitaddr_pkg::ST_IDLE) begin
                        cmd_mode <= hwdata[`CMD_MODE_MSB:`CMD_MODE_LSB];
                        cmd_op   <= hwdata[`CMD_OP_MSB:`CMD_OP_LSB];
                    end
                end
                default: ;
            endcase
        end
    end

    // Test flags follow each pair test
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_flag_one <= 1'b0;
            test_flag_two <= 1'b0;
        end else if (state == bitaddr_pkg::ST_UPDATE && pair_op) begin
            test_flag_one <= flag_one_new;
            test_flag_two <= flag_two_new;
        end
    end

    // Read data, unmapped offsets read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr)
                `OFS_CTRL:    hrdata <= ctrl;
                `OFS_POINTER: hrdata <= {9'h000, extended_aux_pointer};
                `OFS_FIRST:   hrdata <= {16'h0000, first_offset_reg};
                `OFS_SECOND:  hrdata <= {16'h0000, second_offset_reg};
                `OFS_PTRZERO: hrdata <= {9'h000, extended_aux_pointer_zero};
                `OFS_BSTART:  hrdata <= {16'h0000, buffer_start_value};
                `OFS_ACC_LO:  hrdata <= acc[31:0];
                `OFS_ACC_HI:  hrdata <= {24'h000000, acc[`ACC_W-1:32]};
                `OFS_CMD:     hrdata <= {26'h0, cmd_op, 1'b0, cmd_mode};
                `OFS_STATUS:  hrdata <= {29'h0, busy, test_flag_two,
                                         test_flag_one};
                `OFS_ADDR:    hrdata <= {9'h000, bit_addr};
                default:      hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_REV_DEC: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == bitaddr_pkg::ST_UPDATE && cmd_mode == 3'h0)
        |=> extended_aux_pointer == $past(rev_sum))
        else $error("reverse decrement result wrong");
    AST_COMPAT: assert property (@(posedge hclk) disable iff (!hresetn)
        compat_mode_bit |-> rev_operand == extended_aux_pointer_zero)
        else $error("compat subtrahend wrong");
    AST_CIRC_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == bitaddr_pkg::ST_ADDR && cmd_mode == 3'h0) |=>
        bit_addr == $past(extended_aux_pointer) + $past(start_term))
        else $error("circular start not added");
    AST_INC: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == bitaddr_pkg::ST_UPDATE && cmd_mode == 3'h1) |=>
        extended_aux_pointer == $past(extended_aux_pointer)
        + sext($past(second_offset_reg)))
        else $error("increment by second offset wrong");
    AST_DEC: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == bitaddr_pkg::ST_UPDATE && cmd_mode == 3'h2) |=>
        extended_aux_pointer == $past(extended_aux_pointer)
        - sext($past(second_offset_reg)))
        else $error("decrement by second offset wrong");
    AST_IDX: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == bitaddr_pkg::ST_UPDATE && cmd_mode == 3'h3) |=>
        $stable(extended_aux_pointer))
        else $error("indexed form moved pointer");
    AST_PAIR: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == bitaddr_pkg::ST_UPDATE && cmd_op == 2'h2 && bit_addr < 23'd39)
        |=> test_flag_one == $past(acc[bit_addr[5:0]]))
        else $error("flag one not copied");
    AST_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == bitaddr_pkg::ST_UPDATE && cmd_op == 2'h0 && bit_addr < 23'd40)
        |=> acc[$past(bit_addr[5:0])])
        else $error("bit not set");
    AST_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == bitaddr_pkg::ST_UPDATE && cmd_op == 2'h1 && bit_addr < 23'd40)
        |=> !acc[$past(bit_addr[5:0])])
        else $error("bit not cleared");

endmodule // bit_access_address_gen

// ==== testbench/test_bit_access_address_gen.sv ====
// Self-checking testbench for the bit-address block over AHB-Lite
`timescale 1ns/1ps
`include "bitaddr_defines.svh"

module test_bit_access_address_gen;

    // ****************************************
    // Signals and design instance
    // ****************************************
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        test_flag_one;
    logic        test_flag_two;
    logic        busy;
    int          fails;
    int          compares;

    // The single slave drives the bus ready
    assign hready = hreadyout;

    bit_access_address_gen i_dut (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hready),
        .hrdata        (hrdata),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .test_flag_one (test_flag_one),
        .test_flag_two (test_flag_two),
        .busy          (busy)
    );

    // ****************************************
    // Clock, watchdog and verdict
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // Tests need a few hundred cycles at most
    initial begin
        #(25 * 20000);
        fails = fails + 1;
        stop_test();
    end

    task automatic stop_test();
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic check32(input string nm, input logic [31:0] exp,
                           input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Address phase held until hready, then data phase until hready
    task automatic ahb_xfer(input logic [11:0] a, input logic wr,
                            input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb_xfer(a, 1'b1, d, x);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        ahb_xfer(a, 1'b0, 32'h0000_0000, d);
    endtask

    // Load every operand register and the accumulator
    task automatic setup(input logic [1:0] ctrl, input logic [22:0] p,
                         input logic [15:0] t0, input logic [15:0] t1,
                         input logic [22:0] z, input logic [15:0] bs,
                         input logic [39:0] acc);
        wr(`OFS_CTRL, {30'h0, ctrl});
        wr(`OFS_POINTER, {9'h0, p});
        wr(`OFS_FIRST, {16'h0, t0});
        wr(`OFS_SECOND, {16'h0, t1});
        wr(`OFS_PTRZERO, {9'h0, z});
        wr(`OFS_BSTART, {16'h0, bs});
        wr(`OFS_ACC_LO, acc[31:0]);
        wr(`OFS_ACC_HI, {24'h0, acc[39:32]});
    endtask

    // Issue one command and wait for the busy bit to drop
    task automatic run_cmd(input bitaddr_pkg::mode_e m,
                           input bitaddr_pkg::op_e o);
        logic [31:0] s;
        int          n;
        wr(`OFS_CMD, {26'h0, o, 1'b0, m});
        s = 32'hffff_ffff;
        n = 0;
        while (s[2] !== 1'b0 && n < 20) begin
            rd(`OFS_STATUS, s);
            n = n + 1;
        end
        check32("busy_done", 32'h0, {31'h0, s[2]});
        check32("busy_port", 32'h0, {31'h0, busy});
    endtask

    // Compare pointer, bit address, accumulator and flags
    task automatic expect_res(input logic [22:0] p, input logic [22:0] a,
                              input logic [39:0] acc, input logic [1:0] fl);
        logic [31:0] v;
        rd(`OFS_POINTER, v);
        check32("pointer", {9'h0, p}, v);
        rd(`OFS_ADDR, v);
        check32("bit_addr", {9'h0, a}, v);
        rd(`OFS_ACC_LO, v);
        check32("acc_lo", acc[31:0], v);
        rd(`OFS_ACC_HI, v);
        check32("acc_hi", {24'h0, acc[39:32]}, v);
        rd(`OFS_STATUS, v);
        check32("status_flags", {30'h0, fl}, {30'h0, v[1:0]});
        check32("flag_ports", {30'h0, fl},
                {30'h0, test_flag_two, test_flag_one});
    endtask

    // Reference for carries running from the top bit down
    function automatic logic [22:0] mirror(input logic [22:0] v);
        logic [22:0] r;
        for (int i = 0; i < 23; i++) begin
            r[i] = v[22 - i];
        end
        return r;
    endfunction

    function automatic logic [22:0] rev_sub(input logic [22:0] p,
                                            input logic [22:0] o);
        return mirror(mirror(p) - mirror(o));
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset();
        logic [31:0] v;
        rd(`OFS_POINTER, v);
        check32("pointer_rst", `RST_WORD, v);
        check32("hresp_okay", 32'h0, {31'h0, hresp});
        check32("hreadyout_high", 32'h1, {31'h0, hreadyout});
        rd(`OFS_STATUS, v);
        check32("status_rst", `RST_WORD, v);
        wr(12'h3fc, 32'hdead_beef);
        rd(12'h3fc, v);
        check32("unmapped", 32'h0, v);
    endtask

    // Bit-reverse decrement by first offset, bit set at address zero
    task automatic test_rev_first();
        setup(2'b00, 23'h000000, 16'h0003, 16'h0007, 23'h400001, 16'h0,
              40'h0);
        run_cmd(bitaddr_pkg::MODE_REV_DEC, bitaddr_pkg::OP_SET);
        expect_res(rev_sub(23'h0, 23'h3), 23'h0, 40'h1, 2'b00);
    endtask

    // Compatibility mode takes pointer zero as subtrahend
    task automatic test_rev_zero();
        setup(2'b01, 23'h000010, 16'h0003, 16'h0007, 23'h400001, 16'h0,
              40'h0);
        run_cmd(bitaddr_pkg::MODE_REV_DEC, bitaddr_pkg::OP_NONE);
        expect_res(rev_sub(23'h10, 23'h400001), 23'h10, 40'h0, 2'b00);
    endtask

    // Circular start added to the address only, pair test at 16 and 17
    task automatic test_rev_circ();
        setup(2'b10, 23'h000020, 16'h0000, 16'h0000, 23'h0, 16'hfff0,
              40'h00_0002_0000);
        run_cmd(bitaddr_pkg::MODE_REV_DEC, bitaddr_pkg::OP_PAIR);
        expect_res(23'h20, 23'h10, 40'h00_0002_0000, 2'b10);
    endtask

    // Increment by second offset with pair test at 30 and 31
    task automatic test_inc_pair();
        setup(2'b00, 23'd30, 16'h0, 16'd5, 23'h0, 16'h0,
              40'h00_4000_0000);
        run_cmd(bitaddr_pkg::MODE_INC_SEC, bitaddr_pkg::OP_PAIR);
        expect_res(23'd35, 23'd30, 40'h00_4000_0000, 2'b01);
    endtask

    // Decrement by second offset below zero, clear bit 2, flags kept
    task automatic test_dec_clear();
        setup(2'b00, 23'd2, 16'h0, 16'd5, 23'h0, 16'h0, 40'hff_ffff_ffff);
        run_cmd(bitaddr_pkg::MODE_DEC_SEC, bitaddr_pkg::OP_CLEAR);
        expect_res(23'h7ffffd, 23'd2, 40'hff_ffff_fffb, 2'b01);
    endtask

    // Indexed form, clear bit 15, pointer kept
    task automatic test_idx_clear();
        setup(2'b00, 23'd0, 16'h0, 16'd15, 23'h0, 16'h0, 40'hff_ffff_ffff);
        run_cmd(bitaddr_pkg::MODE_IDX_SEC, bitaddr_pkg::OP_CLEAR);
        expect_res(23'd0, 23'd15, 40'hff_ffff_7fff, 2'b01);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        fails    = 0;
        compares = 0;
        hresetn  = 1'b0;
        hsel     = 1'b0;
        haddr    = 12'h000;
        htrans   = 2'b00;
        hwrite   = 1'b0;
        hsize    = 3'h2;
        hwdata   = 32'h0000_0000;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset();
        test_rev_first();
        test_rev_zero();
        test_rev_circ();
        test_inc_pair();
        test_dec_clear();
        test_idx_clear();
        stop_test();
    end

endmodule // test_bit_access_address_gen
